// [hw/btu_defines.vh]
// Register offsets, field positions and reset values of the basic update timer.
// Assumes a byte-addressed register port with 16-bit registers in the low bits of each word.
`ifndef BTU_DEFINES_VH
`define BTU_DEFINES_VH
`define BTU_ADDR_W 8
`define BTU_OFF_CTRL 8'h00
`define BTU_OFF_IE 8'h0C
`define BTU_OFF_STS 8'h10
`define BTU_OFF_EGR 8'h14
`define BTU_OFF_CNT 8'h24
`define BTU_OFF_PSC 8'h28
`define BTU_OFF_ARR 8'h2C
`define BTU_OFF_TRIG 8'h30
`define BTU_CTRL_RUN 0
`define BTU_CTRL_UDIS 1
`define BTU_CTRL_USRC 2
`define BTU_CTRL_DIR0 4
`define BTU_CTRL_DIR1 5
`define BTU_CTRL_ARPE 7
`define BTU_IE_UIE 0
`define BTU_IE_UDE 8
`define BTU_STS_UIF 0
`define BTU_EGR_UG 0
`define BTU_TRIG_GO 0
`define BTU_RST_ARR 16'hFFFF
`define BTU_RST_ZERO 16'h0000
`define BTU_DIR_UP 2'h0
`define BTU_DIR_DOWN 2'h1
`define BTU_DIR_CENTER 2'h2
`endif

// [hw/btu_prescaler.v]
// Prescaler divider: produces one tick every (prescale_value+1) enabled clocks.
// Assumes the caller restarts it on every forced update; overflow updates fall on its own wrap.
`timescale 1ns/1ps
`include "btu_defines.vh"
module btu_prescaler #(
  parameter W = 16
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  input wire ce,
  // Control
  input wire run,
  input wire restart,
  input wire [W-1:0] div_value,
  // Tick out
  output wire tick
);
  reg [W-1:0] div_reg;
  reg [W-1:0] div_next;

  assign tick = run && !restart && (div_reg == div_value);

  always @* begin
    div_next = div_reg;
    if (restart) begin
      div_next = {W{1'b0}};
    end else if (run) begin
      if (div_reg == div_value) begin
        div_next = {W{1'b0}};
      end else begin
        div_next = div_reg + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div_reg <= {W{1'b0}};
    end else if (ce) begin
      div_reg <= div_next;
    end
  end
endmodule // btu_prescaler

// [hw/btu_timer.v]
// Basic 16-bit time base with update event, update interrupt and update DMA request.
// Assumes a single-cycle register port on clk_sys and a trigger input on the same clock.
`timescale 1ns/1ps
`include "btu_defines.vh"
module btu_timer #(
  parameter W = 16
) (
  // Clock, reset and enable
  input wire clk_sys,
  input wire rst,
  input wire ce,
  // Register port
  input wire [`BTU_ADDR_W-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // Trigger from a timer controller on this clock
  input wire trig_in,
  // Requests
  output wire irq,
  output reg dma_req
);
  reg [7:0] ctrl_reg;
  reg update_irq_enable_reg;
  reg update_dma_enable_reg;
  reg update_flag_reg;
  reg [W-1:0] count_value_reg;
  reg [W-1:0] psc_reg;
  reg [W-1:0] psc_active_reg;
  reg [W-1:0] reload_limit_reg;
  reg [W-1:0] reload_active_reg;
  reg dir_down_reg;
  reg [W-1:0] count_next;
  reg dir_down_next;
  reg wrap;
  reg [7:0] ctrl_next;
  reg update_irq_enable_next;
  reg update_dma_enable_next;
  reg update_flag_next;
  reg dma_req_next;
  reg [W-1:0] psc_next;
  reg [W-1:0] psc_active_next;
  reg [W-1:0] reload_limit_next;
  reg [W-1:0] reload_active_next;
  reg [31:0] reg_rdata_next;

  wire counter_run = ctrl_reg[`BTU_CTRL_RUN];
  wire update_disable = ctrl_reg[`BTU_CTRL_UDIS];
  wire update_source_select = ctrl_reg[`BTU_CTRL_USRC];
  wire reload_preload_enable = ctrl_reg[`BTU_CTRL_ARPE];
  wire [1:0] dir_mode = ctrl_reg[`BTU_CTRL_DIR1:`BTU_CTRL_DIR0];
  wire wr_ctrl = reg_wr && (reg_addr == `BTU_OFF_CTRL);
  wire wr_sts = reg_wr && (reg_addr == `BTU_OFF_STS);
  wire wr_cnt = reg_wr && (reg_addr == `BTU_OFF_CNT);
  wire wr_arr = reg_wr && (reg_addr == `BTU_OFF_ARR);
  wire wr_ie = reg_wr && (reg_addr == `BTU_OFF_IE);
  wire wr_psc = reg_wr && (reg_addr == `BTU_OFF_PSC);
  wire update_generate = reg_wr && (reg_addr == `BTU_OFF_EGR) &&
    reg_wdata[`BTU_EGR_UG];
  wire trig_go = (reg_wr && (reg_addr == `BTU_OFF_TRIG) && reg_wdata[`BTU_TRIG_GO]) || trig_in;
  wire count_ok = counter_run && (reload_active_reg != {W{1'b0}});
  wire tick;
  // A forced or triggered reinit always restarts the counter, even with updates disabled.
  wire reinit = update_generate || trig_go;
  wire ovf_event = tick && wrap && !update_disable;
  // Overflow always lands on the prescaler's own wrap, so only a forced update restarts it;
  // feeding overflow back into the restart would loop through the tick.
  wire forced_update = reinit && !update_disable;
  wire upd_event = ovf_event || forced_update;
  wire req_event = ovf_event ||
    (reinit && !update_disable && !update_source_select);

  btu_prescaler #(.W(W)) u_psc (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .run(count_ok),
    .restart(forced_update),
    .div_value(psc_active_reg),
    .tick(tick)
  );

  // Next count; wrap marks an overflow or underflow on this tick.
  always @* begin
    count_next = count_value_reg;
    dir_down_next = dir_down_reg;
    wrap = 1'b0;
    case (dir_mode)
      `BTU_DIR_UP: begin
        dir_down_next = 1'b0;
        wrap = (count_value_reg == reload_active_reg);
        count_next = wrap ? {W{1'b0}} : count_value_reg + {{(W-1){1'b0}}, 1'b1};
      end
      `BTU_DIR_DOWN: begin
        dir_down_next = 1'b1;
        wrap = (count_value_reg == {W{1'b0}});
        count_next = wrap ? reload_active_reg : count_value_reg - {{(W-1){1'b0}}, 1'b1};
      end
      default: begin
        if (dir_down_reg) begin
          wrap = (count_value_reg == {{(W-1){1'b0}}, 1'b1});
          count_next = count_value_reg - {{(W-1){1'b0}}, 1'b1};
          if (wrap) begin
            dir_down_next = 1'b0;
          end
        end else begin
          wrap = (count_value_reg == reload_active_reg - {{(W-1){1'b0}}, 1'b1});
          count_next = count_value_reg + {{(W-1){1'b0}}, 1'b1};
          if (wrap) begin
            dir_down_next = 1'b1;
          end
        end
      end
    endcase
    // A reinit beats a register write, which beats a tick.
    if (reinit) begin
      if (dir_mode == `BTU_DIR_DOWN) begin
        count_next = reload_active_reg;
      end else begin
        count_next = {W{1'b0}};
      end
      dir_down_next = (dir_mode == `BTU_DIR_DOWN);
    end else if (wr_cnt) begin
      count_next = reg_wdata[W-1:0];
      dir_down_next = dir_down_reg;
    end else if (!tick) begin
      count_next = count_value_reg;
      dir_down_next = dir_down_reg;
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count_value_reg <= `BTU_RST_ZERO;
      dir_down_reg <= 1'b0;
    end else if (ce) begin
      count_value_reg <= count_next;
      dir_down_reg <= dir_down_next;
    end
  end

  // Control, enable, prescale and limit registers as software wrote them.
  always @* begin
    ctrl_next = ctrl_reg;
    update_irq_enable_next = update_irq_enable_reg;
    update_dma_enable_next = update_dma_enable_reg;
    psc_next = psc_reg;
    reload_limit_next = reload_limit_reg;
    if (wr_ctrl) begin
      // Reserved bits are stored as zero so that they read back as zero.
      ctrl_next = {reg_wdata[7], 1'b0, reg_wdata[5:4], 1'b0, reg_wdata[2:0]};
    end
    if (wr_ie) begin
      update_irq_enable_next = reg_wdata[`BTU_IE_UIE];
      update_dma_enable_next = reg_wdata[`BTU_IE_UDE];
    end
    if (wr_psc) begin
      // The new factor reaches the divider only at the next update event.
      psc_next = reg_wdata[W-1:0];
    end
    if (wr_arr) begin
      reload_limit_next = reg_wdata[W-1:0];
    end
  end

  // A low clock enable freezes every register, read data included.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_reg <= 8'h00;
    end else if (ce) begin
      ctrl_reg <= ctrl_next;
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      update_irq_enable_reg <= 1'b0;
      update_dma_enable_reg <= 1'b0;
    end else if (ce) begin
      update_irq_enable_reg <= update_irq_enable_next;
      update_dma_enable_reg <= update_dma_enable_next;
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      psc_reg <= `BTU_RST_ZERO;
    end else if (ce) begin
      psc_reg <= psc_next;
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reload_limit_reg <= `BTU_RST_ARR;
    end else if (ce) begin
      reload_limit_reg <= reload_limit_next;
    end
  end

  // Status flag and update DMA request.
  always @* begin
    update_flag_next = update_flag_reg;
    // Set wins over a simultaneous software clear.
    if (req_event) begin
      update_flag_next = 1'b1;
    end else if (wr_sts && !reg_wdata[`BTU_STS_UIF]) begin
      update_flag_next = 1'b0;
    end
    // One single-cycle pulse per qualifying update.
    dma_req_next = req_event && update_dma_enable_reg;
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      update_flag_reg <= 1'b0;
    end else if (ce) begin
      update_flag_reg <= update_flag_next;
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dma_req <= 1'b0;
    end else if (ce) begin
      dma_req <= dma_req_next;
    end
  end

  // Active copies of limit and prescaler.
  always @* begin
    reload_active_next = reload_active_reg;
    psc_active_next = psc_active_reg;
    // Active limit: direct when preload is off, else loaded on update.
    if (wr_arr && !reload_preload_enable) begin
      reload_active_next = reg_wdata[W-1:0];
    end else if (upd_event) begin
      reload_active_next = reload_limit_reg;
    end
    if (upd_event) begin
      psc_active_next = psc_reg;
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reload_active_reg <= `BTU_RST_ARR;
    end else if (ce) begin
      reload_active_reg <= reload_active_next;
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      psc_active_reg <= `BTU_RST_ZERO;
    end else if (ce) begin
      psc_active_reg <= psc_active_next;
    end
  end

  // Read data stands for one cycle after the strobe and is zero otherwise.
  always @* begin
    reg_rdata_next = 32'h00000000;
    if (reg_rd) begin
      case (reg_addr)
        `BTU_OFF_CTRL: reg_rdata_next = {24'h000000, ctrl_reg};
        `BTU_OFF_IE: reg_rdata_next = {23'h000000, update_dma_enable_reg, 7'h00,
          update_irq_enable_reg};
        `BTU_OFF_STS: reg_rdata_next = {31'h00000000, update_flag_reg};
        `BTU_OFF_CNT: reg_rdata_next = {{(32-W){1'b0}}, count_value_reg};
        `BTU_OFF_PSC: reg_rdata_next = {{(32-W){1'b0}}, psc_reg};
        `BTU_OFF_ARR: reg_rdata_next = {{(32-W){1'b0}}, reload_limit_reg};
        // Write-only strobes read as zero.
        `BTU_OFF_EGR: reg_rdata_next = 32'h00000000;
        `BTU_OFF_TRIG: reg_rdata_next = 32'h00000000;
        default: reg_rdata_next = 32'h00000000;
      endcase
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else if (ce) begin
      reg_rdata <= reg_rdata_next;
    end
  end

  assign irq = update_flag_reg && update_irq_enable_reg;
endmodule // btu_timer

// [dv/btu_timer_properties.sv]
// Port assertions of the basic update timer.
// Assumes ce stays high; control bits are shadowed from register writes.
`timescale 1ns/1ps
module btu_checker (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  input wire ce,
  // Register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  // Trigger and requests
  input wire trig_in,
  input wire irq,
  input wire dma_req
);
  reg run_reg, udis_reg, usrc_reg, uie_reg, ude_reg;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) {run_reg, udis_reg, usrc_reg, uie_reg, ude_reg} <= 5'h00;
    else if (reg_wr && reg_addr == 8'h00) {usrc_reg, udis_reg, run_reg} <= reg_wdata[2:0];
    else if (reg_wr && reg_addr == 8'h0C) {ude_reg, uie_reg} <= {reg_wdata[8], reg_wdata[0]};
  end
  wire open_src = !udis_reg && !usrc_reg;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_ug;
    reg_wr && reg_addr == 8'h14 && reg_wdata[0];
  endsequence
  sequence s_clr;
    reg_wr && reg_addr == 8'h10 && !reg_wdata[0];
  endsequence
  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside a read");
  a_ug_dma_pulse: assert property (s_ug ##0 (open_src && ude_reg) |=> dma_req)
    else $error("no dma request after forced update");
  a_ug_irq_set: assert property (s_ug ##0 (open_src && uie_reg) |=> irq)
    else $error("no interrupt after forced update");
  a_trig_dma_pulse: assert property (trig_in && open_src && ude_reg |=> dma_req)
    else $error("no dma request after trigger");
  a_udis_no_dma: assert property (udis_reg |=> !dma_req)
    else $error("dma request while updates disabled");
  a_usrc_quiet: assert property (usrc_reg && !run_reg && !$past(run_reg) |=> !dma_req)
    else $error("dma request from excluded source");
  a_flag_hold: assert property (irq && !(reg_wr && reg_addr[7:2] inside {6'h03, 6'h04}) |=> irq)
    else $error("interrupt dropped by itself");
  a_flag_clear: assert property (s_clr ##0 (!run_reg && !$past(run_reg) && !trig_in) |=> !irq)
    else $error("interrupt stays after flag clear");
endmodule // btu_checker
bind btu_timer btu_checker btu_checker_inst (.clk_sys, .rst, .ce, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .trig_in, .irq, .dma_req);

// [dv/btu_timer_bench.sv]
// Self-checking bench of the basic update timer through its register port.
// Assumes ce tied high and a 20 MHz clock.
`timescale 1ns/1ps
module btu_timer_bench;
  reg clk_sys = 1'b0;
  reg rst = 1'b1;
  reg [7:0] reg_addr = 8'h00;
  reg [31:0] reg_wdata = 32'h0;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg trig_in = 1'b0;
  wire [31:0] reg_rdata;
  wire irq;
  wire dma_req;
  integer fail_count = 0;
  integer compares = 0;
  integer n;
  always #25 clk_sys = ~clk_sys;
  btu_timer btu_timer_inst (.clk_sys(clk_sys), .rst(rst), .ce(1'b1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .trig_in(trig_in), .irq(irq), .dma_req(dma_req));
  task complete_run;
    begin
      if (fail_count == 0 && compares > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task check(input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // Each access leaves a gap cycle so a strobe is never raised where it was lowered.
  task wr(input [7:0] a, input [15:0] d);
    begin
      reg_addr <= a;
      reg_wdata <= {16'h0000, d};
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      @(posedge clk_sys);
    end
  endtask
  task rd(input [7:0] a, input [15:0] e);
    begin
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 check(reg_rdata, {16'h0000, e});
      @(posedge clk_sys);
    end
  endtask
  task period(input integer exp);
    integer c;
    begin
      @(negedge clk_sys);
      while (dma_req !== 1'b1) @(negedge clk_sys);
      @(negedge clk_sys);
      c = 1;
      while (dma_req !== 1'b1 && c < 300) begin
        @(negedge clk_sys);
        c = c + 1;
      end
      check(c, exp);
      @(posedge clk_sys);
    end
  endtask
  initial begin
    #200000;
    fail_count = fail_count + 1;
    complete_run;
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    for (n = 0; n < 8; n = n + 1) rd(8'h0C + 8'h04 * n, 16'h0000);
    rd(8'h2C, 16'hFFFF);
    wr(8'h0C, 16'h0101);
    wr(8'h24, 16'h0055);
    wr(8'h14, 16'h0001);
    rd(8'h24, 16'h0000);
    rd(8'h10, 16'h0001);
    check({31'h0, irq}, 32'h1);
    wr(8'h10, 16'h0001);
    rd(8'h10, 16'h0001);
    wr(8'h10, 16'h0000);
    check({31'h0, irq}, 32'h0);
    wr(8'h00, 16'h0010);
    wr(8'h2C, 16'h0007);
    wr(8'h14, 16'h0001);
    rd(8'h24, 16'h0007);
    wr(8'h00, 16'h0020);
    wr(8'h14, 16'h0001);
    rd(8'h24, 16'h0000);
    wr(8'h10, 16'h0000);
    wr(8'h00, 16'h0004);
    wr(8'h14, 16'h0001);
    rd(8'h10, 16'h0000);
    wr(8'h00, 16'h0002);
    wr(8'h14, 16'h0001);
    rd(8'h10, 16'h0000);
    wr(8'h00, 16'h0000);
    trig_in <= 1'b1;
    @(posedge clk_sys);
    trig_in <= 1'b0;
    @(posedge clk_sys);
    rd(8'h10, 16'h0001);
    wr(8'h10, 16'h0000);
    wr(8'h30, 16'h0001);
    rd(8'h10, 16'h0001);
    wr(8'h28, 16'h0002);
    wr(8'h2C, 16'h0005);
    wr(8'h14, 16'h0001);
    wr(8'h00, 16'h0001);
    period(18);
    wr(8'h00, 16'h0000);
    wr(8'h2C, 16'h0000);
    wr(8'h24, 16'h0000);
    wr(8'h00, 16'h0081);
    repeat (20) @(posedge clk_sys);
    rd(8'h24, 16'h0000);
    wr(8'h2C, 16'h0003);
    repeat (10) @(posedge clk_sys);
    rd(8'h24, 16'h0000);
    wr(8'h14, 16'h0001);
    period(12);
    wr(8'h00, 16'h0091);
    period(12);
    wr(8'h00, 16'h00A1);
    wr(8'h14, 16'h0001);
    period(9);
    complete_run;
  end
endmodule // btu_timer_bench
